// ### include/ierf_pkg.sv
// constants for the interrupt enable and request flag block
// assumes an apb slave with 32-bit data, one aligned word per register
package ierf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_EN_TWO     = 8'h00;
    localparam logic [7:0] OFS_EN_THREE   = 8'h04;
    localparam logic [7:0] OFS_EXT_FLAGS  = 8'h08;
    localparam logic [7:0] OFS_TW_FLAGS   = 8'h0C;
    localparam logic [7:0] OFS_PIN_FUNC   = 8'h10;
    localparam logic [7:0] OFS_EDGE_SEL   = 8'h14;
    localparam logic [7:0] OFS_PENDING    = 8'h18;
    // reset values
    localparam logic [7:0] RST_EN_TWO     = 8'h00;
    localparam logic [7:0] RST_EN_THREE   = 8'h3C;
    localparam logic [7:0] RST_EXT_FLAGS  = 8'hC0;
    localparam logic [7:0] RST_TW_FLAGS   = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC   = 8'h00;
    localparam logic [7:0] RST_EDGE_SEL   = 8'h00;
    // writable and fixed masks
    localparam logic [7:0] EN3_RW_MASK    = 8'hC3;
    localparam logic [7:0] EN3_ONES       = 8'h3C;
    localparam logic [7:0] EXT_FLAG_MASK  = 8'h33;
    localparam logic [7:0] EXT_ONES       = 8'hC0;
    localparam logic [7:0] TW_FLAG_MASK   = 8'h3F;
    localparam logic [7:0] PIN_FUNC_MASK  = 8'h33;
    localparam logic [7:0] EDGE_SEL_MASK  = 8'h13;
    // field positions
    localparam int BIT_DT_EN     = 5;
    localparam int BIT_DT_FLAG   = 5;
    localparam int BIT_ADC_EN    = 7;
    localparam int BIT_KEY_EN    = 6;
    localparam int BIT_SER2_EN   = 1;
    localparam int BIT_SER1_EN   = 0;
    localparam int BIT_PIN5      = 5;
    // number of external pins and their bit slots
    localparam int NUM_PINS      = 4;
    localparam int NUM_SRC       = 15;
    localparam int SRC_W         = 4;
    // source codes, lowest code is highest priority
    localparam logic [3:0] SRC_PIN0   = 4'h0;
    localparam logic [3:0] SRC_TIMERA = 4'h5;
    localparam logic [3:0] SRC_ADC    = 4'hA;
endpackage : ierf_pkg

// ### hdl/ierf_edge_detect.sv
// edge detectors for the external interrupt pins
// assumes pin inputs already synchronous to pclk
`timescale 1ns/1ns
module ierf_edge_detect (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [ierf_pkg::NUM_PINS-1:0] pin_in,
    input  wire logic [ierf_pkg::NUM_PINS-1:0] pin_enable,
    input  wire logic [ierf_pkg::NUM_PINS-1:0] rising_sel,
    output logic      [ierf_pkg::NUM_PINS-1:0] edge_hit
);
    import ierf_pkg::*;

    logic [NUM_PINS-1:0] prev_q;  // last sampled level
    logic [NUM_PINS-1:0] prev_d;

    // previous level always tracks, so enabling a pin sees no stale edge
    always_comb begin
        prev_d = pin_in;
    end

    // idle level of these active-low pins is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '1;
        end else begin
            prev_q <= prev_d;
        end
    end

    // one detector per pin
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            assign edge_hit[g] = pin_enable[g] &
                (rising_sel[g] ? (pin_in[g] & ~prev_q[g])
                               : (~pin_in[g] & prev_q[g]));
        end
    endgenerate
endmodule : ierf_edge_detect

// ### hdl/ierf_priority.sv
// fixed priority picker over gated requests
// assumes the lowest index is the most urgent source
`timescale 1ns/1ns
module ierf_priority (
    input  wire logic [ierf_pkg::NUM_SRC-1:0] req,
    output logic                              any,
    output logic [ierf_pkg::SRC_W-1:0]        idx
);
    import ierf_pkg::*;

    // first set bit from the bottom
    function automatic logic [SRC_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = SRC_W'(i);
            end
        end
        return r;
    endfunction : first_set

    always_comb begin
        any = |req;
        idx = first_set(req);
    end
endmodule : ierf_priority

// ### hdl/ierf_top.sv
// interrupt enable and request flag registers with apb access
// assumes apb master, pin and peripheral events synchronous to pclk
`timescale 1ns/1ns
module ierf_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata_q,
    output logic                               pready_q,
    output logic                               pslverr_q,
    input  wire logic [ierf_pkg::NUM_PINS-1:0] ext_pin_n,
    input  wire logic [4:0]                    timer_overflow,
    input  wire logic                          subactive_mode,
    input  wire logic                          direct_transfer_on,
    input  wire logic                          low_speed_on,
    input  wire logic                          sleep_exec,
    input  wire logic                          adc_done_flag,
    input  wire logic                          key_scan_flag,
    input  wire logic                          serial_two_flag,
    input  wire logic                          serial_one_flag,
    input  wire logic                          condition_code_mask,
    output logic                               irq_req_q,
    output logic      [ierf_pkg::SRC_W-1:0]    irq_source_q
);
    import ierf_pkg::*;
    // map: one byte per aligned word
    //   enable two, enable three,
    //   pin flags, timer and wake flags,
    //   pin function, edge select,
    //   read-only view of gated request slots 0..7
    // single clock domain, pclk only
    // upper data bits read zero, dropped on write

    // software visible storage
    logic [7:0] en_two_q;       // int_enable_two
    logic [7:0] en_two_d;
    logic [7:0] en_three_q;     // int_enable_three, writable bits only
    logic [7:0] en_three_d;
    logic [7:0] ext_flags_q;    // ext_pin_request_flags
    logic [7:0] ext_flags_d;
    logic [7:0] tw_flags_q;     // timer_wake_request_flags
    logic [7:0] tw_flags_d;
    logic [7:0] pin_func_q;     // pin_function_select
    logic [7:0] pin_func_d;
    logic [7:0] edge_sel_q;     // edge_select_reg
    logic [7:0] edge_sel_d;

    // bus side registers
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;

    // interrupt outputs
    logic             irq_req_d;
    logic [SRC_W-1:0] irq_source_d;

    // decoded access strobes
    // taken straight from the bus inputs, plus registered ready for the write
    logic       wr_en;          // write takes effect this edge
    logic [7:0] wbyte;          // low byte of write data
    logic       addr_hit;       // address maps to a register
    logic [7:0] rd_byte;        // selected register value

    // pin event wiring
    // detector slots 0..3 serve pins 0, 1, 4, 5
    logic [NUM_PINS-1:0] pin_enable;
    logic [NUM_PINS-1:0] rising_sel;
    logic [NUM_PINS-1:0] edge_hit;
    logic [7:0]          ext_set;
    logic [7:0]          tw_set;
    logic                dt_set;

    // gated requests and the winner
    // one slot per source plus a spare
    logic [NUM_SRC-1:0] gated;
    logic               any_req;
    logic [SRC_W-1:0]   win_idx;

    // register read value with fixed bits merged in
    // fixed bits merged at read time, not stored,
    // so no flop can hold a wrong constant
    function automatic logic [7:0] read_reg(input logic [7:0] ofs,
                                            input logic [7:0] e2,
                                            input logic [7:0] e3,
                                            input logic [7:0] xf,
                                            input logic [7:0] tf,
                                            input logic [7:0] pf,
                                            input logic [7:0] es,
                                            input logic [7:0] pend);
        logic [7:0] r;
        r = 8'h00;
        unique case (ofs)
            OFS_EN_TWO:    r = e2;
            OFS_EN_THREE:  r = (e3 & EN3_RW_MASK) | EN3_ONES;
            OFS_EXT_FLAGS: r = (xf & EXT_FLAG_MASK) | EXT_ONES;
            OFS_TW_FLAGS:  r = tf & TW_FLAG_MASK;
            OFS_PIN_FUNC:  r = pf & PIN_FUNC_MASK;
            OFS_EDGE_SEL:  r = es & EDGE_SEL_MASK;
            OFS_PENDING:   r = pend;
            default:       r = 8'h00;
        endcase
        return r;
    endfunction : read_reg

    // offset decode shared by read and error logic
    // any address above the low byte is unmapped
    function automatic logic is_mapped(input logic [31:0] a);
        logic m;
        m = (a[31:8] == 24'h000000) &&
            (a[7:0] == OFS_EN_TWO    || a[7:0] == OFS_EN_THREE ||
             a[7:0] == OFS_EXT_FLAGS || a[7:0] == OFS_TW_FLAGS ||
             a[7:0] == OFS_PIN_FUNC  || a[7:0] == OFS_EDGE_SEL ||
             a[7:0] == OFS_PENDING);
        return m;
    endfunction : is_mapped

    // access strobes, write lands only on the completing edge
    // ready is high one access cycle only, so a
    // lingering penable never writes twice
    always_comb begin
        addr_hit = is_mapped(paddr);
        wr_en    = psel & penable & pready_q & pwrite & addr_hit;
        wbyte    = pwdata[7:0];
    end

    // pin slot mapping: flag bits 0,1,4,5 to detectors 0..3
    // pin five has no edge select, tied to falling
    always_comb begin
        pin_enable = {pin_func_q[5], pin_func_q[4], pin_func_q[1], pin_func_q[0]};
        rising_sel = {1'b0, edge_sel_q[4], edge_sel_q[1], edge_sel_q[0]};
    end

    // edge detection for the four external pins
    // pins come in step with pclk, no sync stage;
    // an asynchronous pin needs one outside
    ierf_edge_detect u_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (ext_pin_n),
        .pin_enable (pin_enable),
        .rising_sel (rising_sel),
        .edge_hit   (edge_hit)
    );

    // hardware set terms for both flag registers
    // one-cycle strobes; a held level keeps
    // setting the flag every cycle
    always_comb begin
        ext_set = {2'b00, edge_hit[3], edge_hit[2], 2'b00, edge_hit[1], edge_hit[0]};
        dt_set  = subactive_mode & direct_transfer_on & ~low_speed_on &
                  en_two_q[BIT_DT_EN] & sleep_exec;
        tw_set  = {2'b00, dt_set, timer_overflow};
    end

    // next state for enables and configuration
    // only committed writes move these
    // enable-two top bits kept as written
    always_comb begin
        en_two_d   = en_two_q;
        en_three_d = en_three_q;
        pin_func_d = pin_func_q;
        edge_sel_d = edge_sel_q;
        if (wr_en) begin
            unique case (paddr[7:0])
                OFS_EN_TWO:   en_two_d   = wbyte;
                OFS_EN_THREE: en_three_d = wbyte & EN3_RW_MASK;
                OFS_PIN_FUNC: pin_func_d = wbyte & PIN_FUNC_MASK;
                OFS_EDGE_SEL: edge_sel_d = wbyte & EDGE_SEL_MASK;
                default: begin
                    // other offsets leave these alone
                end
            endcase
        end
    end

    // next state for request flags
    // clear mask from zero bits of the data;
    // a one leaves its flag untouched
    // set is or-ed last so a request in the
    // clearing cycle is never dropped
    always_comb begin
        logic [7:0] ext_clr;
        logic [7:0] tw_clr;
        ext_clr = 8'h00;
        tw_clr  = 8'h00;
        if (wr_en && paddr[7:0] == OFS_EXT_FLAGS) begin
            ext_clr = ~wbyte & EXT_FLAG_MASK;
        end
        if (wr_en && paddr[7:0] == OFS_TW_FLAGS) begin
            tw_clr = ~wbyte & TW_FLAG_MASK;
        end
        ext_flags_d = ((ext_flags_q & ~ext_clr) | ext_set) & EXT_FLAG_MASK;
        tw_flags_d  = ((tw_flags_q & ~tw_clr) | tw_set) & TW_FLAG_MASK;
    end

    // register state, reset values from the package
    // async reset keeps flags quiet before pclk runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_two_q    <= RST_EN_TWO;
            en_three_q  <= RST_EN_THREE & EN3_RW_MASK;
            ext_flags_q <= RST_EXT_FLAGS & EXT_FLAG_MASK;
            tw_flags_q  <= RST_TW_FLAGS;
            pin_func_q  <= RST_PIN_FUNC;
            edge_sel_q  <= RST_EDGE_SEL;
        end else begin
            en_two_q    <= en_two_d;
            en_three_q  <= en_three_d;
            ext_flags_q <= ext_flags_d;
            tw_flags_q  <= tw_flags_d;
            pin_func_q  <= pin_func_d;
            edge_sel_q  <= edge_sel_d;
        end
    end

    // request gating by the individual enables
    // the external-pin enables live in another register, so pin
    // flags here are gated only by their pin function selection
    // slot order is priority order, low index wins
    // slot fourteen unused, held low
    always_comb begin
        gated[0] = ext_flags_q[0] & pin_func_q[0];
        gated[1] = ext_flags_q[1] & pin_func_q[1];
        gated[2] = ext_flags_q[4] & pin_func_q[4];
        gated[3] = ext_flags_q[5] & pin_func_q[BIT_PIN5];
        gated[4] = tw_flags_q[BIT_DT_FLAG] & en_two_q[BIT_DT_EN];
        gated[9:5] = tw_flags_q[4:0] & en_two_q[4:0];
        gated[10] = adc_done_flag & en_three_q[BIT_ADC_EN];
        gated[11] = key_scan_flag & en_three_q[BIT_KEY_EN];
        gated[12] = serial_one_flag & en_three_q[BIT_SER1_EN];
        gated[13] = serial_two_flag & en_three_q[BIT_SER2_EN];
        gated[14] = 1'b0;  // spare slot, never requests
    end

    // fixed priority among enabled requests
    // combinational; result registered below
    ierf_priority u_prio (
        .req (gated),
        .any (any_req),
        .idx (win_idx)
    );

    // request to the core, held back by the global mask
    // mask only hides the request; flags and source
    // keep tracking so nothing is lost meanwhile
    // source holds its last value when idle
    always_comb begin
        irq_req_d    = any_req & ~condition_code_mask;
        irq_source_d = any_req ? win_idx : irq_source_q;
    end

    // registered interrupt outputs, one cycle behind the flags
    // a cycle of latency traded for flop outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req_q    <= 1'b0;
            irq_source_q <= SRC_PIN0;
        end else begin
            irq_req_q    <= irq_req_d;
            irq_source_q <= irq_source_d;
        end
    end

    // apb answer: ready in the first access cycle, data latched in setup
    // no wait states, every access ends after one cycle
    // data captured at setup and held to next setup,
    // so a flag set mid-access shows on the next read
    // unmapped addresses give error and zero data
    always_comb begin
        rd_byte   = read_reg(paddr[7:0], en_two_q, en_three_q, ext_flags_q,
                             tw_flags_q, pin_func_q, edge_sel_q, gated[7:0]);
        pready_d  = psel & ~penable;
        pslverr_d = psel & ~penable & ~addr_hit;
        prdata_d  = prdata_q;
        if (psel && !penable) begin
            // unmapped or write access reads back zero
            prdata_d = (addr_hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // bus response registers
    // ready and error are single-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end
endmodule : ierf_top

// ### tb/ierf_chk.sv
// checker for the enable and flag block
// assumes it is bound onto ierf_top
`timescale 1ns/1ns
module ierf_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_q,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    input wire logic        condition_code_mask,
    input wire logic        irq_req_q
);
    import ierf_pkg::*;
    logic       acc;          // committed transfer
    logic       rd_ok;        // committed read
    logic [7:0] en2_q, en2_d; // shadow of enable two
    logic [7:0] en3_q, en3_d; // shadow of enable three
    assign acc   = psel && penable && pready_q;
    assign rd_ok = acc && !pwrite;
    // shadows move only on committed writes
    always_comb begin
        en2_d = en2_q;
        en3_d = en3_q;
        if (acc && pwrite && paddr == {24'h0, OFS_EN_TWO}) begin
            en2_d = pwdata[7:0];
        end
        if (acc && pwrite && paddr == {24'h0, OFS_EN_THREE}) begin
            en3_d = (pwdata[7:0] & EN3_RW_MASK) | EN3_ONES;
        end
    end
    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en2_q <= RST_EN_TWO;
            en3_q <= RST_EN_THREE;
        end else begin
            en2_q <= en2_d;
            en3_q <= en3_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_setup: assert property (psel && !penable |=> pready_q)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    chk_unmapped_err: assert property (psel && !penable && paddr[31:8] != 24'h0 |=> pslverr_q)
        else $error("unmapped address without error");
    chk_rdata_upper: assert property (pready_q |-> prdata_q[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_en2_readback: assert property (
        rd_ok && paddr == {24'h0, OFS_EN_TWO} |-> prdata_q[7:0] == en2_q)
        else $error("enable two read mismatch");
    chk_en3_readback: assert property (
        rd_ok && paddr == {24'h0, OFS_EN_THREE} |-> prdata_q[7:0] == en3_q)
        else $error("enable three read mismatch");
    chk_ext_fixed: assert property (
        rd_ok && paddr == {24'h0, OFS_EXT_FLAGS} |->
        prdata_q[7:6] == 2'h3 && prdata_q[3:2] == 2'h0)
        else $error("pin flag fixed bits wrong");
    chk_tw_fixed: assert property (
        rd_ok && paddr == {24'h0, OFS_TW_FLAGS} |-> prdata_q[7:6] == 2'h0)
        else $error("timer flag top bits not zero");
    chk_mask_holds: assert property (condition_code_mask |=> !irq_req_q)
        else $error("request passed the global mask");
    cov_write: cover property (acc && pwrite);
    cov_tw_read: cover property (rd_ok && paddr == {24'h0, OFS_TW_FLAGS});
    cov_irq: cover property ($rose(irq_req_q));
endmodule : ierf_chk
bind ierf_top ierf_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .condition_code_mask(condition_code_mask), .irq_req_q(irq_req_q));

// ### tb/ierf_src_model.sv
// pin, timer, mode and peripheral sources facing the flag block
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/1ns
module ierf_src_model (
    input  wire logic  pclk,
    output logic [3:0] ext_pin_n,          // pin0, pin1, pin4, pin5; idle high
    output logic [4:0] timer_overflow,     // timers e..a
    output logic [2:0] mode_lv,            // low speed, transfer on, subactive
    output logic       sleep_exec,         // sleep strobe
    output logic [3:0] periph_lv,          // adc, key scan, serial two, one
    output logic       condition_code_mask // cpu global mask
);
    // quiet at time zero so no edge is seen at reset release
    initial begin
        ext_pin_n = 4'hF;
        timer_overflow = 5'h00;
        mode_lv = 3'h0;
        sleep_exec = 1'b0;
        periph_lv = 4'h0;
        condition_code_mask = 1'b0;
    end
    task automatic pulse_timer(input logic [4:0] m);
        @(posedge pclk);
        timer_overflow <= m;
        @(posedge pclk);
        timer_overflow <= 5'h00;
    endtask : pulse_timer
    task automatic sleep_wake();
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
    endtask : sleep_wake
    // mode, peripheral and mask levels, moved after an edge
    task automatic set_lv(input logic [2:0] m, input logic [3:0] p, input logic c);
        mode_lv <= m;
        periph_lv <= p;
        condition_code_mask <= c;
    endtask : set_lv
    task automatic pin_set(input logic [3:0] v);
        @(posedge pclk);
        ext_pin_n <= v;
        @(posedge pclk);
    endtask : pin_set
endmodule : ierf_src_model

// ### tb/ierf_top_tb_top.sv
// self-checking bench for the enable and flag block
// assumes the package, design, checker and source model compiled first
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module ierf_top_tb_top;
    import ierf_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata_q, r;
    logic        pready_q, pslverr_q, irq_req_q, sleep_exec, condition_code_mask, err;
    logic [3:0]  irq_source_q, ext_pin_n, periph_lv;
    logic [4:0]  timer_overflow;
    logic [2:0]  mode_lv;
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    logic [7:0]  e2 = RST_EN_TWO, e3 = RST_EN_THREE, xf = RST_EXT_FLAGS, tf = RST_TW_FLAGS;
    logic [7:0]  pf = RST_PIN_FUNC, es = RST_EDGE_SEL;
    logic [31:0] ofs [9] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14, 32'h18, 32'h1C, 32'h100};
    logic [7:0]  e3b [4] = '{8'h01, 8'h02, 8'h40, 8'h80};
    logic [2:0]  md [4] = '{3'h7, 3'h2, 3'h1, 3'h3};
    initial forever #2 pclk = ~pclk;
    ierf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .ext_pin_n(ext_pin_n),
        .timer_overflow(timer_overflow), .subactive_mode(mode_lv[0]),
        .direct_transfer_on(mode_lv[1]), .low_speed_on(mode_lv[2]), .sleep_exec(sleep_exec),
        .adc_done_flag(periph_lv[3]), .key_scan_flag(periph_lv[2]),
        .serial_two_flag(periph_lv[1]), .serial_one_flag(periph_lv[0]),
        .condition_code_mask(condition_code_mask), .irq_req_q(irq_req_q),
        .irq_source_q(irq_source_q));
    ierf_src_model src (.pclk(pclk), .ext_pin_n(ext_pin_n), .timer_overflow(timer_overflow),
        .mode_lv(mode_lv), .sleep_exec(sleep_exec), .periph_lv(periph_lv),
        .condition_code_mask(condition_code_mask));
    // counts, verdict and the only exit
    task automatic print_verdict();
        $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 16);
        if (pready_q !== 1'b1) miscompares++;
        r = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // write plus model update
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        case (a[7:0])
            OFS_EN_TWO:    e2 = d;
            OFS_EN_THREE:  e3 = (d & EN3_RW_MASK) | EN3_ONES;
            OFS_EXT_FLAGS: xf = xf & (d | ~EXT_FLAG_MASK);
            OFS_TW_FLAGS:  tf = tf & (d | ~TW_FLAG_MASK);
            OFS_PIN_FUNC:  pf = d & PIN_FUNC_MASK;
            OFS_EDGE_SEL:  es = d & EDGE_SEL_MASK;
            default:       ;
        endcase
    endtask : wr
    // read compared with model
    task automatic rd(input logic [31:0] a);
        logic [7:0] x;
        case (a)
            32'h0:   x = e2;
            32'h4:   x = e3;
            32'h8:   x = xf;
            32'hC:   x = tf;
            32'h10:  x = pf;
            32'h14:  x = es;
            default: x = 8'h00;
        endcase
        apb(1'b0, a, 32'h0);
        `CHK(r, {24'h0, x})
        `CHK(err, (a > 32'h18))
    endtask : rd
    // model of gating and priority, low code wins
    task automatic chk_irq();
        logic [13:0] q;
        int w;
        repeat (2) @(posedge pclk);
        q = '0;
        for (int i = 0; i < 6; i++) q[i+4] = tf[(i+5)%6] & e2[(i+5)%6];
        q[3:0] = {xf[5] & pf[5], xf[4] & pf[4], xf[1] & pf[1], xf[0] & pf[0]};
        q[13:10] = {periph_lv[1] & e3[1], periph_lv[0] & e3[0], periph_lv[2] & e3[6],
                    periph_lv[3] & e3[7]};
        w = -1;
        for (int i = 13; i >= 0; i--) if (q[i]) w = i;
        `CHK(irq_req_q, ((w >= 0) && !condition_code_mask))
        if (w >= 0 && !condition_code_mask) `CHK(irq_source_q, 4'(w))
    endtask : chk_irq
    // cycle ceiling against hangs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'hdaea));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) rd(ofs[i]);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(32'h0, 8'($urandom()));
            wr(32'h4, 8'($urandom()));
            wr(32'h8, 8'($urandom()));
            wr(32'hC, 8'($urandom()) & 8'h3F);
            foreach (ofs[i]) if (i < 4) rd(ofs[i]);
        end
        $display("test enables done");
        wr(32'h0, 8'h00);
        src.pulse_timer(5'h1F);
        tf = 8'h1F;
        rd(32'hC);
        chk_irq();
        wr(32'hC, 8'h3F);
        rd(32'hC);
        wr(32'h0, 8'h03);
        chk_irq();
        src.set_lv(mode_lv, periph_lv, 1'b1);
        chk_irq();
        rd(32'hC);
        src.set_lv(mode_lv, periph_lv, 1'b0);
        wr(32'hC, 8'h3E);
        chk_irq();
        fork
            wr(32'hC, 8'h00);
            begin
                @(posedge pclk);
                src.pulse_timer(5'h04);
            end
        join
        tf = 8'h04;
        rd(32'hC);
        wr(32'hC, 8'h00);
        $display("test timers done");
        src.set_lv(3'h3, periph_lv, condition_code_mask);
        src.sleep_wake();
        rd(32'hC);
        wr(32'h0, 8'h20);
        foreach (md[i]) begin
            src.set_lv(md[i], periph_lv, condition_code_mask);
            src.sleep_wake();
            if (md[i] == 3'h3) tf[5] = 1'b1;
            rd(32'hC);
        end
        chk_irq();
        wr(32'hC, 8'h00);
        wr(32'h0, 8'h00);
        $display("test direct transfer done");
        foreach (e3b[i]) begin
            src.set_lv(mode_lv, 4'(4'h1 << i), condition_code_mask);
            wr(32'h4, e3b[i]);
            chk_irq();
            wr(32'h4, 8'h00);
            chk_irq();
        end
        src.set_lv(mode_lv, 4'hF, condition_code_mask);
        wr(32'h4, 8'hC3);
        chk_irq();
        src.set_lv(mode_lv, 4'h0, condition_code_mask);
        $display("test peripherals done");
        src.pin_set(4'hE);
        src.pin_set(4'hF);
        rd(32'h8);
        wr(32'h10, 8'h33);
        wr(32'h14, 8'h13);
        src.pin_set(4'h4);
        xf[5] = 1'b1;
        src.pin_set(4'hB);
        xf[1:0] = 2'h3;
        rd(32'h8);
        chk_irq();
        wr(32'h8, 8'hDF);
        rd(32'h8);
        src.pin_set(4'hF);
        xf[4] = 1'b1;
        rd(32'h8);
        rd(32'h14);
        $display("test pins done");
        print_verdict();
    end
endmodule : ierf_top_tb_top
